// ==== bench/tb.sv ====
// Self-checking bench: AXI4-Lite software plus a bus master model.
// Assumes the block and its checker; clock enable stays high except for one short drop in s_read.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic aclk, aresetn, ce, arb_lost, scl_in, sda_in;
	logic scl_out, scl_oe, sda_out, sda_oe;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int bad_count = 0;
	int n_tests = 0;
	logic [1:0] wr_resp;

	twowire_slave_tx_status i_twowire_slave_tx_status (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .arb_lost(arb_lost),
		.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
	);
	twowire_master_model i_twowire_master_model (.scl_oe(scl_oe),
		.sda_oe(sda_oe), .scl(scl_in), .sda(sda_in));

	// ==========================================================
	// Shared tasks
	task report_and_stop;
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// Margin for the pad synchronisers before looking at status
	task stat(input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		repeat (4) @(posedge aclk);
		rd(4'h4, d, r);
		chk("status", e, d[7:0]);
	endtask

	// ==========================================================
	// Scenarios
	task s_idle;
		logic [31:0] d;
		logic [1:0] r;
		rd(4'h0, d, r);
		chk("ctrl reset", 8'h00, d[7:0]);
		rd(4'hc, d, r);
		chk("addr reset", 8'h00, d[7:0]);
		stat(8'hf8);
		rd(4'h2, d, r);
		chk("unmapped resp", 8'h02, {6'h0, r});
		chk("unmapped data", 8'h00, d[7:0]);
		wr(4'hc, 8'h54);
		chk("write resp", 8'h00, {6'h0, wr_resp});
		wr(4'h2, 8'h00);
		chk("unmapped wresp", 8'h02, {6'h0, wr_resp});
		wr(4'h0, 8'h44);
	endtask
	task s_read;
		logic ack;
		logic [7:0] d;
		// Clock enable low: this loss pulse must not be kept
		@(posedge aclk);
		ce <= 0;
		arb_lost <= 1;
		@(posedge aclk);
		arb_lost <= 0;
		@(posedge aclk);
		ce <= 1;
		i_twowire_master_model.start;
		i_twowire_master_model.addr(7'h2a, 1, ack);
		chk("own ack", 8'h01, {7'h0, ack});
		stat(8'ha8);
		chk("scl held", 8'h01, {7'h0, scl_oe});
		wr(4'h8, 8'ha5);
		wr(4'h0, 8'hc4);
		stat(8'hf8);
		i_twowire_master_model.rdbyte(1, d);
		chk("byte msb first", 8'ha5, d);
		stat(8'hb8);
		wr(4'h8, 8'h3c);
		wr(4'h0, 8'h84);
		i_twowire_master_model.rdbyte(1, d);
		chk("last byte", 8'h3c, d);
		stat(8'hc8);
		wr(4'h0, 8'hc4);
		i_twowire_master_model.rdbyte(0, d);
		chk("after last", 8'hff, d);
		i_twowire_master_model.stop;
	endtask
	task s_arb;
		logic ack;
		logic [7:0] d;
		@(posedge aclk);
		arb_lost <= 1;
		@(posedge aclk);
		arb_lost <= 0;
		i_twowire_master_model.start;
		i_twowire_master_model.addr(7'h2a, 1, ack);
		stat(8'hb0);
		wr(4'h8, 8'h81);
		wr(4'h0, 8'hc4);
		i_twowire_master_model.rdbyte(0, d);
		chk("nacked byte", 8'h81, d);
		stat(8'hc0);
		wr(4'h0, 8'h84);
		i_twowire_master_model.stop;
		i_twowire_master_model.start;
		i_twowire_master_model.addr(7'h2a, 1, ack);
		chk("own ignored", 8'h00, {7'h0, ack});
		wr(4'h0, 8'h44);
		i_twowire_master_model.start;
		i_twowire_master_model.addr(7'h00, 1, ack);
		chk("broadcast off", 8'h00, {7'h0, ack});
		i_twowire_master_model.stop;
	endtask
	task s_buserr;
		logic ack, b;
		logic [31:0] d;
		logic [1:0] r;
		i_twowire_master_model.start;
		i_twowire_master_model.addr(7'h2a, 1, ack);
		chk("own ack again", 8'h01, {7'h0, ack});
		// All ones so SDA is free for a misplaced START
		wr(4'h8, 8'hff);
		wr(4'h0, 8'hc4);
		repeat (3) i_twowire_master_model.get(b);
		i_twowire_master_model.start;
		stat(8'h00);
		chk("lines free", 8'h00, {6'h0, scl_oe, sda_oe});
		wr(4'h0, 8'hd4);
		rd(4'h0, d, r);
		chk("ctrl kept", 8'h44, d[7:0]);
		stat(8'hf8);
		chk("no stop", 8'h00, {6'h0, scl_oe, sda_oe});
		i_twowire_master_model.stop;
	endtask
	task s_master;
		logic [31:0] d;
		logic [1:0] r;
		wr(4'h0, 8'h64);
		repeat (90) @(posedge aclk);
		stat(8'h08);
		chk("start lines", 8'h03, {6'h0, scl_oe, sda_oe});
		wr(4'h0, 8'he4);
		repeat (170) @(posedge aclk);
		stat(8'h10);
		chk("rstart lines", 8'h03, {6'h0, scl_oe, sda_oe});
		wr(4'h0, 8'hd4);
		repeat (90) @(posedge aclk);
		rd(4'h0, d, r);
		chk("stop done", 8'h44, d[7:0]);
		chk("bus freed", 8'h00, {6'h0, scl_oe, sda_oe});
	endtask
	task s_bcast;
		logic ack;
		logic [7:0] d;
		wr(4'hc, 8'h55);
		i_twowire_master_model.start;
		i_twowire_master_model.addr(7'h00, 1, ack);
		chk("broadcast on", 8'h01, {7'h0, ack});
		stat(8'ha8);
		wr(4'h8, 8'h5a);
		wr(4'h0, 8'h84);
		i_twowire_master_model.rdbyte(0, d);
		chk("broadcast byte", 8'h5a, d);
		stat(8'hc0);
		wr(4'h0, 8'h84);
		i_twowire_master_model.stop;
	endtask

	// ==========================================================
	// Clock, reset, sequence and watchdog
	initial begin
		aclk = 0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		{aresetn, arb_lost, s_axi_awvalid, s_axi_wvalid} = 4'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		ce = 1;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		s_idle;
		s_read;
		s_arb;
		s_buserr;
		s_master;
		s_bcast;
		report_and_stop;
	end
	// Whole run needs well under a millisecond
	initial begin
		#2000000;
		bad_count++;
		report_and_stop;
	end
endmodule

`default_nettype wire

// ==== bench/twowire_assertions.sv ====
// Checker for the two-wire slave transmitter, bound into the block.
// Assumes it sees only the block's register bus and pad ports.
`timescale 1ns/1ps
`default_nettype none

module twowire_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out
);
	// ==========================================================
	// Helper state
	// Offset of the read under way, so read data can be judged
	logic [3:0] rd_ofs;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_ofs <= 4'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_ofs <= s_axi_araddr;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// Properties
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bresp not held");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rdata not held");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_ar_gate;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_gate: assert property (p_ar_gate) else $error("arready while busy");
	property p_aw_gate;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_gate: assert property (p_aw_gate) else $error("write taken early");
	property p_stat_zero;
		s_axi_rvalid && rd_ofs == 4'h4 |->
			s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[1:0] == 2'b00;
	endproperty
	a_stat_zero: assert property (p_stat_zero) else $error("status bits");
	// Pads only ever pull low; high comes from the pull-ups
	property p_pads;
		scl_out == 1'b0 && sda_out == 1'b0;
	endproperty
	a_pads: assert property (p_pads) else $error("pad driven high");
	// Software needs at least a bus write to free a held clock
	property p_stretch;
		$rose(scl_oe) |-> scl_oe [*3];
	endproperty
	a_stretch: assert property (p_stretch) else $error("SCL hold short");
endmodule

bind twowire_slave_tx_status twowire_assertions i_twowire_assertions (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.scl_out(scl_out),
	.scl_oe(scl_oe),
	.sda_out(sda_out)
);

`default_nettype wire

// ==== bench/twowire_master_model.sv ====
// Behavioural two-wire bus master receiver with pull-up wires.
// Assumes the block's pad enables; SCL idles high between frames.
`timescale 1ns/1ps
`default_nettype none

module twowire_master_model (
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	// ==========================================================
	// Wires: any party pulling low wins
	logic m_scl = 1'b0;
	logic m_sda = 1'b0;
	assign scl = !(scl_oe || m_scl);
	assign sda = !(sda_oe || m_sda);

	// One bit, 400 ns; waits out a stretched clock
	task put(input logic b);
		m_sda = !b;
		#100;
		m_scl = 0;
		while (scl !== 1'b1) #10;
		#200;
		m_scl = 1;
		#100;
	endtask
	task get(output logic b);
		m_sda = 0;
		#100;
		m_scl = 0;
		while (scl !== 1'b1) #10;
		#100;
		b = sda;
		#100;
		m_scl = 1;
		#100;
	endtask
	// also a repeated start, no STOP between
	task start;
		m_sda = 0;
		#100;
		m_scl = 0;
		while (scl !== 1'b1) #10;
		#100;
		m_sda = 1;
		#200;
		m_scl = 1;
		#100;
	endtask
	task stop;
		m_sda = 1;
		#100;
		m_scl = 0;
		while (scl !== 1'b1) #10;
		#200;
		m_sda = 0;
		#200;
	endtask
	task addr(input logic [6:0] a, input logic rw, output logic ack);
		logic b;
		for (int i = 6; i >= 0; i--) put(a[i]);
		put(rw);
		get(b);
		ack = !b;
	endtask
	task rdbyte(input logic ack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get(d[i]);
		put(!ack);
	endtask
endmodule

`default_nettype wire

// ==== logic/twowire_slave_tx_status.sv ====
// Two-wire slave transmitter with status codes, bus error handling
// and a small START / REPEATED START generator.
// Assumes an AXI4-Lite master on aclk and open-drain bus pads outside.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "twowire_params.svh"
`default_nettype none

module twowire_slave_tx_status (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic arb_lost,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);

	// ==========================================================
	// Register bus
	logic [3:0] aw_addr;
	logic aw_full;
	logic [7:0] w_data;
	logic w_lane;
	logic w_full;
	logic wr_en;
	logic sw_clear;
	logic flag;
	logic ack_en;
	logic start_req;
	logic stop_req;
	logic enable;
	logic [6:0] own_addr;
	logic bcast_en;
	logic [7:0] data_reg;
	logic [7:0] status_code;
	logic arb_q;
	logic set_pulse;
	logic [7:0] set_code;
	logic start_done;
	logic stop_done;

	function automatic logic mapped(input logic [3:0] a);
		mapped = (a == `TW_OFS_CTRL) || (a == `TW_OFS_STAT) ||
			(a == `TW_OFS_DATA) || (a == `TW_OFS_ADDR);
	endfunction

	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_en = aw_full && w_full && !s_axi_bvalid;
	assign sw_clear = wr_en && w_lane && aw_addr == `TW_OFS_CTRL &&
		w_data[`TW_BIT_DONE];

	// Address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 8'h00;
			w_lane <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata[7:0];
				w_lane <= s_axi_wstrb[0];
			end
			if (wr_en) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read path; status shows idle code whenever no step is pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
				s_axi_rdata <= 32'h0;
				unique case (s_axi_araddr)
					`TW_OFS_CTRL: s_axi_rdata[7:0] <= {flag, ack_en,
						start_req, stop_req, 1'b0, enable, 2'b00};
					`TW_OFS_STAT: s_axi_rdata[7:0] <= flag ?
						{status_code[7:3], 3'b000} : `TW_ST_IDLE;
					`TW_OFS_DATA: s_axi_rdata[7:0] <= data_reg;
					`TW_OFS_ADDR: s_axi_rdata[7:0] <= {own_addr, bcast_en};
					default: s_axi_rdata <= 32'h0;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Step-done flag; a hardware set beats a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag <= 1'b0;
			status_code <= `TW_ST_IDLE;
		end else if (ce) begin
			if (set_pulse) begin
				flag <= 1'b1;
				status_code <= set_code;
			end else if (sw_clear) begin
				flag <= 1'b0;
			end
		end
	end

	// Control bits; hardware only ever clears start and stop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{ack_en, start_req, stop_req, enable} <= 4'h0;
			{own_addr, bcast_en} <= `TW_ADDR_RESET;
			data_reg <= 8'h00;
		end else if (ce) begin
			if (start_done)
				start_req <= 1'b0;
			if (stop_done)
				stop_req <= 1'b0;
			if (wr_en && w_lane) begin
				unique case (aw_addr)
					`TW_OFS_CTRL: begin
						ack_en <= w_data[`TW_BIT_ACK];
						start_req <= w_data[`TW_BIT_START];
						stop_req <= w_data[`TW_BIT_STOP];
						enable <= w_data[`TW_BIT_EN];
					end
					`TW_OFS_DATA: data_reg <= w_data;
					`TW_OFS_ADDR: {own_addr, bcast_en} <= w_data;
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Bus line sampling
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_d;
	logic sda_d;
	logic scl_now;
	logic sda_now;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic bus_busy;

	// Lines reset high so release of reset shows no false edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else if (ce) begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_d <= scl_sync[1];
			sda_d <= sda_sync[1];
		end
	end

	assign scl_now = scl_sync[1];
	assign sda_now = sda_sync[1];
	assign scl_rise = scl_now && !scl_d;
	assign scl_fall = !scl_now && scl_d;
	assign start_c = scl_now && scl_d && sda_d && !sda_now;
	assign stop_c = scl_now && scl_d && !sda_d && sda_now;

	// Bus is owned by someone between START and STOP
	always_ff @(posedge aclk) begin
		if (!aresetn)
			bus_busy <= 1'b0;
		else if (ce && start_c)
			bus_busy <= 1'b1;
		else if (ce && stop_c)
			bus_busy <= 1'b0;
	end

	// Arbitration loss from the master logic waits for an address
	always_ff @(posedge aclk) begin
		if (!aresetn)
			arb_q <= 1'b0;
		else if (ce && arb_lost)
			arb_q <= 1'b1;
		else if (ce && set_pulse && set_code == `TW_ST_ARB_SLA_R)
			arb_q <= 1'b0;
	end

	// ==========================================================
	// Bus engine
	twowire_pkg::engine_t state;
	twowire_pkg::hold_t hold_kind;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic last;
	logic rep;
	logic [7:0] timer;
	logic scl_low;
	logic sda_low;
	logic in_frame;
	logic hit;

	// own address needs ack enable, broadcast needs ack enable and its own enable
	assign hit = ack_en && ((shreg[6:0] == own_addr) ||
		(shreg[6:0] == 7'h00 && bcast_en));
	assign in_frame = (state == twowire_pkg::st_addr && bit_cnt != 4'h0)
		|| state == twowire_pkg::st_addr_ack
		|| state == twowire_pkg::st_tx || state == twowire_pkg::st_tx_ack;

	always_ff @(posedge aclk) begin
		if (!aresetn || (ce && !enable)) begin
			state <= twowire_pkg::st_idle;
			hold_kind <= twowire_pkg::hold_tx;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			{last, rep, scl_low, sda_low} <= 4'h0;
			{set_pulse, start_done, stop_done} <= 3'h0;
			set_code <= `TW_ST_IDLE;
			timer <= 8'h00;
		end else if (ce) begin
			{set_pulse, start_done, stop_done} <= 3'h0;
			if ((start_c || stop_c) && in_frame) begin
				{scl_low, sda_low} <= 2'b00;
				set_pulse <= 1'b1;
				set_code <= `TW_ST_BUS_ERR;
				hold_kind <= twowire_pkg::hold_error;
				state <= twowire_pkg::st_hold;
			end else begin
				unique case (state)
					twowire_pkg::st_idle: begin
						if (start_c) begin
							bit_cnt <= 4'h0;
							state <= twowire_pkg::st_addr;
						// START once the bus is free
						end else if (start_req && !bus_busy) begin
							sda_low <= 1'b1;
							rep <= 1'b0;
							timer <= 8'(`TW_HOLD_CYC);
							state <= twowire_pkg::st_gen;
						end
					end
					twowire_pkg::st_addr: begin
						if (stop_c)
							state <= twowire_pkg::st_idle;
						else if (scl_rise) begin
							shreg <= {shreg[6:0], sda_now};
							bit_cnt <= bit_cnt + 4'h1;
							if (bit_cnt == 4'h7) begin
								bit_cnt <= 4'h0;
								// Only the read direction is served here
								state <= (hit && sda_now) ?
									twowire_pkg::st_addr_ack :
									twowire_pkg::st_idle;
							end
						end
					end
					twowire_pkg::st_addr_ack: begin
						if (scl_fall && bit_cnt == 4'h0) begin
							sda_low <= 1'b1;
							bit_cnt <= 4'h1;
						end else if (scl_fall) begin
							sda_low <= 1'b0;
							scl_low <= 1'b1;
							set_pulse <= 1'b1;
							set_code <= arb_q ? `TW_ST_ARB_SLA_R : `TW_ST_SLA_R;
							hold_kind <= twowire_pkg::hold_tx;
							state <= twowire_pkg::st_hold;
						end
					end
					twowire_pkg::st_hold: begin
						if (!flag && !set_pulse) begin
							unique case (hold_kind)
								// first bit while SCL held low
								twowire_pkg::hold_tx: begin
									shreg <= data_reg;
									last <= !ack_en;
									sda_low <= !data_reg[7];
									bit_cnt <= 4'h0;
									scl_low <= 1'b0;
									state <= twowire_pkg::st_tx;
								end
								twowire_pkg::hold_final: begin
									{scl_low, sda_low} <= 2'b00;
									state <= twowire_pkg::st_idle;
								end
								twowire_pkg::hold_error: begin
									{scl_low, sda_low} <= 2'b00;
									if (stop_req) begin
										stop_done <= 1'b1;
										state <= twowire_pkg::st_idle;
									end
								end
								default: state <= twowire_pkg::st_idle;
							endcase
						end
					end
					// MSB first, change on falling SCL
					twowire_pkg::st_tx: begin
						if (scl_fall) begin
							shreg <= {shreg[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
							sda_low <= !shreg[6];
							if (bit_cnt == 4'h7) begin
								sda_low <= 1'b0;
								bit_cnt <= 4'h0;
								state <= twowire_pkg::st_tx_ack;
							end
						end
					end
					twowire_pkg::st_tx_ack: begin
						if (scl_rise) begin
							bit_cnt <= 4'h1;
							set_code <= sda_now ? `TW_ST_DATA_NACK :
								last ? `TW_ST_LAST_ACK : `TW_ST_DATA_ACK;
							hold_kind <= (sda_now || last) ?
								twowire_pkg::hold_final : twowire_pkg::hold_tx;
						end else if (scl_fall && bit_cnt == 4'h1) begin
							scl_low <= 1'b1;
							set_pulse <= 1'b1;
							state <= twowire_pkg::st_hold;
						end
					end
					twowire_pkg::st_gen: begin
						timer <= timer - 8'h01;
						if (timer == 8'h01) begin
							scl_low <= 1'b1;
							start_done <= 1'b1;
							set_pulse <= 1'b1;
							set_code <= rep ? `TW_ST_RSTART : `TW_ST_START;
							state <= twowire_pkg::st_master;
						end
					end
					// Master data phases live outside this block
					twowire_pkg::st_master: begin
						if (!flag && !set_pulse && stop_req) begin
							scl_low <= 1'b0;
							timer <= 8'(`TW_HOLD_CYC);
							state <= twowire_pkg::st_stop;
						end else if (!flag && !set_pulse && start_req) begin
							{scl_low, sda_low} <= 2'b00;
							rep <= 1'b1;
							timer <= 8'(`TW_HOLD_CYC);
							state <= twowire_pkg::st_rstart;
						end
					end
					twowire_pkg::st_stop: begin
						timer <= timer - 8'h01;
						if (timer == 8'h01) begin
							sda_low <= 1'b0;
							stop_done <= 1'b1;
							state <= twowire_pkg::st_idle;
						end
					end
					twowire_pkg::st_rstart: begin
						timer <= timer - 8'h01;
						if (timer == 8'h01) begin
							sda_low <= 1'b1;
							timer <= 8'(`TW_HOLD_CYC);
							state <= twowire_pkg::st_gen;
						end
					end
				endcase
			end
		end
	end

	// Open drain: drive low only, enable marks the pull
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_low;
	assign sda_oe = sda_low;

endmodule

`default_nettype wire

// ==== shared/twowire_params.svh ====
// Offsets, field positions, status codes and timing counts of the
// two-wire slave transmitter block.
// Assumes a 20 MHz system clock and AXI4-Lite byte addressing.
`ifndef TWOWIRE_PARAMS_SVH
`define TWOWIRE_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define TW_OFS_CTRL 4'h0
`define TW_OFS_STAT 4'h4
`define TW_OFS_DATA 4'h8
`define TW_OFS_ADDR 4'hc

// ==========================================================
// Control field positions
`define TW_BIT_DONE 7
`define TW_BIT_ACK 6
`define TW_BIT_START 5
`define TW_BIT_STOP 4
`define TW_BIT_EN 2

// ==========================================================
// Reset values
`define TW_CTRL_RESET 8'h00
`define TW_ADDR_RESET 8'h00

// ==========================================================
// Status codes, prescaler bits always zero
`define TW_ST_START 8'h08
`define TW_ST_RSTART 8'h10
`define TW_ST_SLA_R 8'ha8
`define TW_ST_ARB_SLA_R 8'hb0
`define TW_ST_DATA_ACK 8'hb8
`define TW_ST_DATA_NACK 8'hc0
`define TW_ST_LAST_ACK 8'hc8
`define TW_ST_IDLE 8'hf8
`define TW_ST_BUS_ERR 8'h00

// ==========================================================
// Timing
`define TW_CLK_MHZ 20
`define TW_HOLD_NS 4000
`define TW_HOLD_CYC (((`TW_HOLD_NS) * (`TW_CLK_MHZ) + 999) / 1000)

`endif

// ==== shared/twowire_pkg.sv ====
// Types shared by the two-wire slave transmitter block.
// Assumes the constants header is included where numbers are needed.
package twowire_pkg;

	// ==========================================================
	// Bus engine states
	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_addr_ack,
		st_tx,
		st_tx_ack,
		st_hold,
		st_gen,
		st_master,
		st_stop,
		st_rstart
	} engine_t;

	// What a held step resumes into once software releases it
	typedef enum logic [1:0] {
		hold_tx,
		hold_final,
		hold_error
	} hold_t;

endpackage
